// [hdl/speed_monitor_defines.vh]
// Constants shared by the speed and standstill monitor
`ifndef SPEED_MONITOR_DEFINES_VH
`define SPEED_MONITOR_DEFINES_VH
// ****************************************
// Clock and timing
// ****************************************
`define SSM_CLK_KHZ 40000
`define SSM_GATE_MS 10
`define SSM_BLINK_MS 250
`define SSM_PROX_FAULT_MS 5
`define SSM_ENC_FAULT_NS 250
`define SSM_ENC_FAULT_CYCLES ((`SSM_ENC_FAULT_NS * `SSM_CLK_KHZ) / 1000000)
`define SSM_GATE_CYCLES (`SSM_GATE_MS * `SSM_CLK_KHZ)
`define SSM_BLINK_CYCLES (`SSM_BLINK_MS * `SSM_CLK_KHZ)
`define SSM_PROX_FAULT_CYCLES (`SSM_PROX_FAULT_MS * `SSM_CLK_KHZ)
// ****************************************
// Register byte offsets
// ****************************************
`define SSM_REG_CTRL 8'h00
`define SSM_REG_GATE 8'h04
`define SSM_REG_STILL_THR 8'h08
`define SSM_REG_SP0 8'h0c
`define SSM_REG_SP1 8'h10
`define SSM_REG_SP2 8'h14
`define SSM_REG_SP3 8'h18
`define SSM_REG_STATUS 8'h1c
`define SSM_REG_FREQ 8'h20
`define SSM_REG_IRQ_STATUS 8'h24
`define SSM_REG_IRQ_CLEAR 8'h28
`define SSM_REG_IRQ_ENABLE 8'h2c
// ****************************************
// Fields and reset values
// ****************************************
`define SSM_CTRL_USE_ENC 0
`define SSM_CTRL_INV_OVER 1
`define SSM_CTRL_INV_STILL 2
`define SSM_CTRL_INV_FAULT 3
`define SSM_CTRL_RESET 4'h0
`define SSM_STILL_THR_RESET 24'h000002
`define SSM_SP_RESET 24'h000064
`define SSM_IRQ_READY 0
`define SSM_IRQ_FAULT 1
`define SSM_IRQ_OVER 2
`define SSM_IRQ_STILL 3
`define SSM_RESP_OKAY 2'b00
`define SSM_RESP_SLVERR 2'b10
`endif

// [hdl/bit_sync.v]
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module bit_sync #(
	parameter WIDTH = 10
)(
	input wire aclk,
	input wire aresetn,
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);
reg [WIDTH-1:0] stage1;

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		stage1 <= {WIDTH{1'b0}};
		dout <= {WIDTH{1'b0}};
	end
	else
	begin
		stage1 <= din;
		dout <= stage1;
	end
end
endmodule // bit_sync

// [hdl/freq_gate.v]
// Counts edge ticks over a programmable gate interval
`timescale 1ns/10ps
module freq_gate #(
	parameter WIDTH = 24
)(
	input wire aclk,
	input wire aresetn,
	input wire tick,
	input wire [WIDTH-1:0] gate_len,
	output reg [WIDTH-1:0] count,
	output reg done
);
reg [WIDTH-1:0] timer;
reg [WIDTH-1:0] acc;

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		timer <= {WIDTH{1'b0}};
		acc <= {WIDTH{1'b0}};
		count <= {WIDTH{1'b0}};
		done <= 1'b0;
	end
	else if (timer + 1'b1 >= gate_len)
	begin
		// A tick in the closing cycle belongs to this interval
		timer <= {WIDTH{1'b0}};
		count <= (&acc) ? acc : acc + {{(WIDTH-1){1'b0}}, tick};
		acc <= {WIDTH{1'b0}};
		done <= 1'b1;
	end
	else
	begin
		timer <= timer + 1'b1;
		if (tick && !(&acc))
			acc <= acc + 1'b1;
		done <= 1'b0;
	end
end
endmodule // freq_gate

// [hdl/safe_speed_standstill_monitor.v]
// Speed and standstill monitor with AXI4-Lite configuration
// Functional notes
// - At rest after reset, see a proximity or valid encoder signal before enabling outputs.
// - When that check passes, operate all relays and assert both signal outputs.
// - Without a fault the fault signal output stays undriven.
// - Standstill outputs hold while frequency is at or below downtime threshold.
// - Overspeed outputs hold while frequency does not exceed the selected setpoint.
// - On a sensor fault drop all relays, flash power LED, drive fault output; the code does this only in run, and the start check just keeps waiting.
// - Each of the three signal outputs can be inverted by configuration.
// - Power LED is steady when ready and flashes after an error.
// - First output LED lit only while frequency is below the overspeed setpoint.
// - Second output LED lit only while frequency is below the downtime threshold.
// - Three mode selects and their common pick the active overspeed setpoint.
// - Encoder path counts edges up to 400 kHz without loss.
// - Proximity path handles edges up to 2 kHz.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "speed_monitor_defines.vh"
module safe_speed_standstill_monitor #(
	parameter [23:0] GATE_RESET = `SSM_GATE_CYCLES,
	parameter BLINK_CYCLES = `SSM_BLINK_CYCLES,
	parameter PROX_FAULT_CYCLES = `SSM_PROX_FAULT_CYCLES
)(
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire proximity_input_a,
	input wire proximity_input_b,
	input wire enc_a,
	input wire enc_a_n,
	input wire enc_b,
	input wire enc_b_n,
	input wire mode_select_0,
	input wire mode_select_1,
	input wire mode_select_2,
	input wire mode_select_common,
	output reg relay_overspeed,
	output reg relay_standstill,
	output reg overspeed_signal_out,
	output reg overspeed_signal_oe,
	output reg standstill_signal_out,
	output reg standstill_signal_oe,
	output reg fault_signal_out,
	output reg fault_signal_oe,
	output reg power_led,
	output reg led_overspeed,
	output reg led_standstill,
	output reg irq
);
localparam ST_CHECK = 2'd0;
localparam ST_RUN = 2'd1;
localparam ST_FAULT = 2'd2;

// ****************************************
// Input conditioning and edge detection
// ****************************************
wire [9:0] sync_in;
wire s_pa;
wire s_pb;
wire s_ea;
wire s_ean;
wire s_eb;
wire s_ebn;
wire s_m0;
wire s_m1;
wire s_m2;
wire s_mc;
reg prev_pa;
reg prev_ea;
wire tick;

bit_sync #(.WIDTH(10)) u_sync (
	.aclk(aclk),
	.aresetn(aresetn),
	.din({proximity_input_a, proximity_input_b, enc_a, enc_a_n, enc_b, enc_b_n,
		mode_select_0, mode_select_1, mode_select_2, mode_select_common}),
	.dout(sync_in)
);
assign {s_pa, s_pb, s_ea, s_ean, s_eb, s_ebn, s_m0, s_m1, s_m2, s_mc} = sync_in;

reg [3:0] ctrl;
wire use_enc = ctrl[`SSM_CTRL_USE_ENC];
// One tick per rising edge of track A or of the first switch
assign tick = use_enc ? (s_ea & ~prev_ea) : (s_pa & ~prev_pa);

// ****************************************
// Registers and frequency gate
// ****************************************
reg [23:0] gate_len;
reg [23:0] still_thr;
reg [23:0] sp [0:3];
reg [3:0] irq_en;
reg [3:0] irq_st;
wire [23:0] freq;
wire gate_done;

freq_gate #(.WIDTH(24)) u_gate (
	.aclk(aclk),
	.aresetn(aresetn),
	.tick(tick),
	.gate_len(gate_len),
	.count(freq),
	.done(gate_done)
);

// Mode selects are ignored unless the common input is active
wire [1:0] sp_idx = !s_mc ? 2'd0 : s_m2 ? 2'd3 : s_m1 ? 2'd2 : s_m0 ? 2'd1 : 2'd0;
wire [23:0] sp_sel = sp[sp_idx];

// ****************************************
// Sensor fault detection
// ****************************************
// Encoder tracks must be complementary; switches must never both rest
wire bad_now = use_enc ? ((s_ea == s_ean) | (s_eb == s_ebn)) : ~(s_pa | s_pb);
wire [31:0] bad_limit = use_enc ? `SSM_ENC_FAULT_CYCLES : PROX_FAULT_CYCLES;
reg [31:0] bad_cnt;
reg good_gate;
wire fault_det = (bad_cnt >= bad_limit);

// ****************************************
// Monitor state machine
// ****************************************
reg [1:0] state;
reg over_ok;
reg still_ok;
reg over_below;
reg still_below;
reg [1:0] next_state;
reg [3:0] events;

always @*
begin
	next_state = state;
	events = 4'h0;
	case (state)
		ST_CHECK:
		begin
			// Leave only after a whole clean gate at rest
			if (gate_done && good_gate && !bad_now && freq <= still_thr)
			begin
				next_state = ST_RUN;
				events[`SSM_IRQ_READY] = 1'b1;
			end
		end
		ST_RUN:
		begin
			if (fault_det)
			begin
				next_state = ST_FAULT;
				events[`SSM_IRQ_FAULT] = 1'b1;
			end
			else if (gate_done)
			begin
				events[`SSM_IRQ_OVER] = over_ok & (freq > sp_sel);
				events[`SSM_IRQ_STILL] = still_ok & (freq > still_thr);
			end
		end
		ST_FAULT:
			next_state = ST_FAULT;
		default:
			next_state = ST_CHECK;
	endcase
end

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		state <= ST_CHECK;
		bad_cnt <= 32'h0;
		good_gate <= 1'b0;
		prev_pa <= 1'b0;
		prev_ea <= 1'b0;
		over_ok <= 1'b0;
		still_ok <= 1'b0;
		over_below <= 1'b0;
		still_below <= 1'b0;
	end
	else
	begin
		state <= next_state;
		prev_pa <= s_pa;
		prev_ea <= s_ea;
		bad_cnt <= bad_now ? ((fault_det) ? bad_cnt : bad_cnt + 32'h1) : 32'h0;
		good_gate <= gate_done ? 1'b1 : (good_gate & ~bad_now);
		if (state == ST_CHECK && next_state == ST_RUN)
		begin
			over_ok <= 1'b1;
			still_ok <= 1'b1;
		end
		else if (gate_done && state == ST_RUN)
		begin
			over_ok <= (freq <= sp_sel);
			still_ok <= (freq <= still_thr);
		end
		if (gate_done)
		begin
			over_below <= (freq < sp_sel);
			still_below <= (freq < still_thr);
		end
	end
end

// ****************************************
// Relays, signal outputs and LEDs
// ****************************************
reg [31:0] blink_cnt;
reg blink;
wire run = (state == ST_RUN);
wire over_act = run & over_ok;
wire still_act = run & still_ok;
wire fault_act = (state == ST_FAULT);
// An active output drives high; inversion swaps driving and undriven
wire next_over_oe = over_act ^ ctrl[`SSM_CTRL_INV_OVER];
wire next_still_oe = still_act ^ ctrl[`SSM_CTRL_INV_STILL];
wire next_fault_oe = fault_act ^ ctrl[`SSM_CTRL_INV_FAULT];

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		blink_cnt <= 32'h0;
		blink <= 1'b0;
		relay_overspeed <= 1'b0;
		relay_standstill <= 1'b0;
		overspeed_signal_out <= 1'b0;
		overspeed_signal_oe <= 1'b0;
		standstill_signal_out <= 1'b0;
		standstill_signal_oe <= 1'b0;
		fault_signal_out <= 1'b0;
		fault_signal_oe <= 1'b0;
		power_led <= 1'b0;
		led_overspeed <= 1'b0;
		led_standstill <= 1'b0;
	end
	else
	begin
		if (blink_cnt + 32'h1 >= BLINK_CYCLES)
		begin
			blink_cnt <= 32'h0;
			blink <= ~blink;
		end
		else
			blink_cnt <= blink_cnt + 32'h1;
		relay_overspeed <= over_act;
		relay_standstill <= still_act;
		overspeed_signal_out <= next_over_oe;
		overspeed_signal_oe <= next_over_oe;
		standstill_signal_out <= next_still_oe;
		standstill_signal_oe <= next_still_oe;
		fault_signal_out <= next_fault_oe;
		fault_signal_oe <= next_fault_oe;
		power_led <= run | (fault_act & blink);
		led_overspeed <= run & over_below;
		led_standstill <= run & still_below;
	end
end

// ****************************************
// AXI4-Lite slave
// ****************************************
function [23:0] wmerge;
	input [23:0] old;
	input [23:0] d;
	input [2:0] s;
	integer i;
	begin
		for (i = 0; i < 3; i = i + 1)
			wmerge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
	end
endfunction

reg aw_full;
reg [7:0] aw_addr;
reg w_full;
reg [31:0] w_data;
reg [3:0] w_strb;
wire do_write = aw_full & w_full & ~s_axi_bvalid;
wire [3:0] irq_clr = (do_write && aw_addr == `SSM_REG_IRQ_CLEAR && w_strb[0]) ? w_data[3:0] : 4'h0;
reg [31:0] rd_word;
reg rd_hit;

always @*
begin
	rd_hit = 1'b1;
	case (s_axi_araddr)
		`SSM_REG_CTRL: rd_word = {28'h0, ctrl};
		`SSM_REG_GATE: rd_word = {8'h0, gate_len};
		`SSM_REG_STILL_THR: rd_word = {8'h0, still_thr};
		`SSM_REG_SP0: rd_word = {8'h0, sp[0]};
		`SSM_REG_SP1: rd_word = {8'h0, sp[1]};
		`SSM_REG_SP2: rd_word = {8'h0, sp[2]};
		`SSM_REG_SP3: rd_word = {8'h0, sp[3]};
		`SSM_REG_STATUS: rd_word = {22'h0, sp_idx, still_below, over_below, still_ok, over_ok, fault_det, bad_now, state};
		`SSM_REG_FREQ: rd_word = {8'h0, freq};
		`SSM_REG_IRQ_STATUS: rd_word = {28'h0, irq_st};
		`SSM_REG_IRQ_CLEAR: rd_word = 32'h0;
		`SSM_REG_IRQ_ENABLE: rd_word = {28'h0, irq_en};
		default:
		begin
			rd_word = 32'h0;
			rd_hit = 1'b0;
		end
	endcase
end

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `SSM_RESP_OKAY;
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0;
		s_axi_rresp <= `SSM_RESP_OKAY;
		aw_full <= 1'b0;
		aw_addr <= 8'h0;
		w_full <= 1'b0;
		w_data <= 32'h0;
		w_strb <= 4'h0;
		ctrl <= `SSM_CTRL_RESET;
		gate_len <= GATE_RESET;
		still_thr <= `SSM_STILL_THR_RESET;
		sp[0] <= `SSM_SP_RESET;
		sp[1] <= `SSM_SP_RESET;
		sp[2] <= `SSM_SP_RESET;
		sp[3] <= `SSM_SP_RESET;
		irq_en <= 4'h0;
		irq_st <= 4'h0;
		irq <= 1'b0;
	end
	else
	begin
		s_axi_awready <= ~aw_full & ~s_axi_awready & ~(s_axi_awvalid & s_axi_awready);
		s_axi_wready <= ~w_full & ~s_axi_wready & ~(s_axi_wvalid & s_axi_wready);
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_full <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_full <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (do_write)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= `SSM_RESP_OKAY;
			case (aw_addr)
				`SSM_REG_CTRL: ctrl <= w_strb[0] ? w_data[3:0] : ctrl;
				`SSM_REG_GATE: gate_len <= wmerge(gate_len, w_data[23:0], w_strb[2:0]);
				`SSM_REG_STILL_THR: still_thr <= wmerge(still_thr, w_data[23:0], w_strb[2:0]);
				`SSM_REG_SP0: sp[0] <= wmerge(sp[0], w_data[23:0], w_strb[2:0]);
				`SSM_REG_SP1: sp[1] <= wmerge(sp[1], w_data[23:0], w_strb[2:0]);
				`SSM_REG_SP2: sp[2] <= wmerge(sp[2], w_data[23:0], w_strb[2:0]);
				`SSM_REG_SP3: sp[3] <= wmerge(sp[3], w_data[23:0], w_strb[2:0]);
				`SSM_REG_IRQ_ENABLE: irq_en <= w_strb[0] ? w_data[3:0] : irq_en;
				`SSM_REG_IRQ_CLEAR: s_axi_bresp <= `SSM_RESP_OKAY;
				default: s_axi_bresp <= `SSM_RESP_SLVERR;
			endcase
		end
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
		s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & ~(s_axi_arvalid & s_axi_arready);
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? `SSM_RESP_OKAY : `SSM_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
		// A new event wins over a clear in the same cycle
		irq_st <= (irq_st & ~irq_clr) | events;
		irq <= |(irq_st & irq_en);
	end
end
endmodule // safe_speed_standstill_monitor

// [verification/ssm_props.sv]
// Port assertions for the speed and standstill monitor
`timescale 1ns/10ps
module ssm_props #(
	parameter BLINK_CYCLES = 8
)(
	input logic aclk,
	input logic aresetn,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic [31:0] s_axi_rdata,
	input logic relay_overspeed,
	input logic relay_standstill,
	input logic overspeed_signal_out,
	input logic overspeed_signal_oe,
	input logic standstill_signal_out,
	input logic standstill_signal_oe,
	input logic fault_signal_out,
	input logic fault_signal_oe,
	input logic power_led,
	input logic led_overspeed,
	input logic led_standstill
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_quiet;
		$rose(aresetn) |-> !relay_overspeed && !relay_standstill && !fault_signal_oe && !power_led; endproperty
	a_quiet: assert property (p_quiet) else $error("output live after reset");
	property p_over_led;
		led_overspeed |-> relay_overspeed; endproperty
	a_over_led: assert property (p_over_led) else $error("overspeed lamp without relay");
	property p_still_led;
		led_standstill |-> relay_standstill; endproperty
	a_still_led: assert property (p_still_led) else $error("standstill lamp without relay");
	property p_pins;
		overspeed_signal_out == overspeed_signal_oe && standstill_signal_out == standstill_signal_oe
			&& fault_signal_out == fault_signal_oe; endproperty
	a_pins: assert property (p_pins) else $error("signal pin level differs from enable");
	// Only a lamp that comes on with both relays dropped is flashing; entering the fault cuts a phase short
	property p_blink;
		$rose(power_led) && !relay_overspeed && !relay_standstill |-> power_led[*8] ##1 !power_led; endproperty
	a_blink: assert property (p_blink) else $error("power lamp flash period wrong");
	property p_drop;
		$fell(power_led) |-> !relay_overspeed && !relay_standstill ##1 !relay_overspeed && !relay_standstill; endproperty
	a_drop: assert property (p_drop) else $error("relay held while flashing");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped early");
	property p_arblock;
		s_axi_rvalid |-> !s_axi_arready; endproperty
	a_arblock: assert property (p_arblock) else $error("read address offered during response");
endmodule // ssm_props
bind safe_speed_standstill_monitor ssm_props #(.BLINK_CYCLES(BLINK_CYCLES)) i_props (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata),
	.relay_overspeed(relay_overspeed),
	.relay_standstill(relay_standstill),
	.overspeed_signal_out(overspeed_signal_out),
	.overspeed_signal_oe(overspeed_signal_oe),
	.standstill_signal_out(standstill_signal_out),
	.standstill_signal_oe(standstill_signal_oe),
	.fault_signal_out(fault_signal_out),
	.fault_signal_oe(fault_signal_oe),
	.power_led(power_led),
	.led_overspeed(led_overspeed),
	.led_standstill(led_standstill)
);

// [verification/motion_sensor_model.sv]
// Behavioural proximity switch pair and quadrature encoder
`timescale 1ns/10ps
module motion_sensor_model (
	input logic aclk,
	input int half,
	input logic brk,
	output logic proximity_input_a = 1,
	output logic proximity_input_b = 0,
	output logic enc_a = 0,
	output logic enc_a_n = 1,
	output logic enc_b = 0,
	output logic enc_b_n = 1
);
	int t = 0;
	wire a = half > 0 && (t / half) % 2 == 1;
	wire b = half > 0 && ((t + half / 2) / half) % 2 == 1;
	// A zero half period is a shaft at rest; brk is the commanded sensor fault
	always @(posedge aclk)
	begin
		t <= half > 0 ? t + 1 : 0;
		proximity_input_a <= !brk && (a || half == 0);
		proximity_input_b <= !brk && !a && half > 0;
		{enc_a, enc_b, enc_b_n} <= {a, b, !b};
		enc_a_n <= brk ? a : !a;
	end
endmodule // motion_sensor_model

// [verification/safe_speed_standstill_monitor_tb.sv]
// Bench for the speed and standstill monitor against an integer model
`timescale 1ns/10ps
module safe_speed_standstill_monitor_tb;
	localparam GATE = 100;
	logic aclk = 0, aresetn = 0, brk = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, brsp;
	logic proximity_input_a, proximity_input_b, enc_a, enc_a_n, enc_b, enc_b_n;
	logic mode_select_0 = 0, mode_select_1 = 0, mode_select_2 = 0, mode_select_common = 0;
	logic relay_overspeed, relay_standstill, overspeed_signal_out, overspeed_signal_oe, standstill_signal_out;
	logic standstill_signal_oe, fault_signal_out, fault_signal_oe, power_led, led_overspeed, led_standstill, irq;
	int half = 0, error_cnt = 0, cmp_count = 0, cyc = 0, sp[4];
	logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h2c};
	logic [31:0] rv[8] = '{32'h0, 32'h64, 32'h2, 32'h64, 32'h64, 32'h64, 32'h64, 32'h0};
	logic [3:0] mt[5] = '{4'h7, 4'h8, 4'h9, 4'ha, 4'hf};
	wire [7:0] ov = {relay_overspeed, relay_standstill, overspeed_signal_oe, standstill_signal_oe, fault_signal_oe,
		power_led, led_overspeed, led_standstill};
	safe_speed_standstill_monitor #(.GATE_RESET(24'h64), .BLINK_CYCLES(8), .PROX_FAULT_CYCLES(50)) i_dut (.*);
	motion_sensor_model i_sensor (.*);
	initial forever #12.5 aclk = ~aclk;
	task automatic w(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic chk(input string n, input logic [31:0] g, e);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		w(1);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			w(1);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		brsp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic hs;
		w(1);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		// A random late rready makes the slave hold its answer
		s_axi_rready <= 1'($urandom);
		do
		begin
			w(1);
			if (s_axi_arready) s_axi_arvalid <= 0;
			hs = s_axi_rvalid && s_axi_rready;
			if (s_axi_rvalid && !hs) s_axi_rready <= 1;
		end while (!hs);
		{rrsp, rdat} = {s_axi_rresp, s_axi_rdata};
		s_axi_rready <= 0;
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			error_cnt++;
			close_out;
		end
	end
	initial
	begin
		int f, j, n;
		logic p;
		void'($urandom(37410));
		w(6);
		aresetn <= 1;
		w(1);
		chk("rst", ov, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			rd(ra[i]);
			chk("reg", rdat, rv[i]);
			chk("rresp", rrsp, 2'h0);
		end
		rd(8'h30);
		chk("unmapped", rrsp, 2'h2);
		wr(8'h20, 32'h5);
		chk("ro_write", brsp, 2'h2);
		$display("test registers done");
		w(3 * GATE);
		chk("run", ov, 8'hf7);
		chk("irq_masked", irq, 1'b0);
		wr(8'h2c, 32'h1);
		w(3);
		chk("irq_on", irq, 1'b1);
		wr(8'h28, 32'h1);
		w(3);
		chk("irq_clr", irq, 1'b0);
		wr(8'h00, 32'he);
		w(2 * GATE);
		chk("invert", ov, 8'hcf);
		wr(8'h00, 32'h0);
		for (int k = 0; k < 5; k++)
		begin
			for (int i = 0; i < 4; i++)
			begin
				sp[i] = 8 + $urandom % 5;
				wr(8'h0c + 8'(4 * i), sp[i]);
			end
			{mode_select_common, mode_select_2, mode_select_1, mode_select_0} <= mt[k];
			half <= 5;
			w(3 * GATE);
			j = !mt[k][3] ? 0 : mt[k][2] ? 3 : mt[k][1] ? 2 : mt[k][0];
			f = GATE / 10;
			chk("speed", ov, {f <= sp[j], 1'b0, f <= sp[j], 3'b001, f < sp[j], 1'b0});
			rd(8'h20);
			chk("freq", rdat, f);
		end
		wr(8'h00, 32'h1);
		half <= 2;
		w(3 * GATE);
		rd(8'h20);
		chk("enc_freq", rdat, GATE / 4);
		chk("enc_over", ov, 8'h04);
		half <= 0;
		w(3 * GATE);
		chk("rearm", ov, 8'hf7);
		$display("test speed done");
		wr(8'h2c, 32'h2);
		brk <= 1;
		w(40);
		chk("fault", {ov[7:3], ov[1:0], irq}, 8'h09);
		rd(8'h1c);
		chk("state", rdat[1:0], 2'h2);
		p = power_led;
		n = 0;
		repeat (64)
		begin
			w(1);
			n += (power_led != p);
			p = power_led;
		end
		chk("blink", n, 8);
		aresetn <= 0;
		brk <= 0;
		w(6);
		aresetn <= 1;
		w(1);
		chk("rst2", ov, 8'h00);
		w(3 * GATE);
		brk <= 1;
		w(100);
		chk("prox_fault", {ov[7:3], ov[1:0]}, 7'h04);
		$display("test faults done");
		close_out;
	end
endmodule // safe_speed_standstill_monitor_tb
